// ==== hw/gio_pkg.sv ====
// gpio port package: register map, field positions, reset values
// assumes a plain register port with one-cycle read latency
package gio_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [4:0] ADDR_PORT_A    = 5'h00;
  localparam logic [4:0] ADDR_PORT_B    = 5'h01;
  localparam logic [4:0] ADDR_PORT_C    = 5'h02;
  localparam logic [4:0] ADDR_DIR_A     = 5'h03;
  localparam logic [4:0] ADDR_DIR_B     = 5'h04;
  localparam logic [4:0] ADDR_DIR_C     = 5'h05;
  localparam logic [4:0] ADDR_PU_A      = 5'h06;
  localparam logic [4:0] ADDR_PU_B      = 5'h07;
  localparam logic [4:0] ADDR_PU_C      = 5'h08;
  localparam logic [4:0] ADDR_PD_AB     = 5'h09;
  localparam logic [4:0] ADDR_PD_C      = 5'h0A;
  localparam logic [4:0] ADDR_OD_B      = 5'h0B;
  localparam logic [4:0] ADDR_OD_C      = 5'h0C;
  localparam logic [4:0] ADDR_CHG_A     = 5'h0D;
  localparam logic [4:0] ADDR_CHG_B     = 5'h0E;
  localparam logic [4:0] ADDR_POWER_CONTROL_REG      = 5'h0F;
  localparam logic [4:0] ADDR_PCON2     = 5'h10;
  localparam logic [4:0] ADDR_INTERRUPT_FLAG_REG      = 5'h11;
  localparam logic [4:0] ADDR_INTERRUPT_ENABLE_REG      = 5'h12;
  localparam logic [4:0] ADDR_INTERRUPT_EDGE_REG    = 5'h13;
  localparam logic [4:0] ADDR_IR_CONTROL_REG      = 5'h14;
  localparam logic [4:0] ADDR_ALTCTL    = 5'h15;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_PA5_PU      = 4;  // power control
  localparam int BIT_PA5_PD      = 5;  // group a pull-up ctrl
  localparam int BIT_LVL_FLAG    = 1;  // flag / enable registers
  localparam int BIT_GIE         = 7;  // power control 2
  localparam int BIT_EXT_INT0_SELECT        = 4;
  localparam int BIT_EXT_INT1_SELECT        = 5;
  localparam int BIT_EXT_INT2_SELECT        = 6;
  localparam int BIT_IR_CARRIER_ENABLE        = 0;
  // alternate control register
  localparam int BIT_TIMER0_SOURCE_SEL        = 0;
  localparam int BIT_T0LCK       = 1;
  localparam int BIT_TIMER1_SOURCE_SEL        = 2;
  localparam int BIT_PWM1OE      = 3;
  localparam int BIT_PWM2OE      = 4;
  localparam int BIT_PWM3OE      = 5;
  localparam int BIT_BUZZER2_ENABLE       = 6;
  localparam int BIT_BUZZER3_ENABLE       = 7;
  localparam int BIT_T1OE        = 8;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_DIR    = 8'hFF;  // all inputs
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [8:0] RST_ALT    = 9'h000;

endpackage

// ==== hw/gio_port.sv ====
// gpio port: 18 pins in groups a (8), b (8), c (2), alternate functions
// assumes pads resolve level from out/oe; cfg_* straps are static words
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module gio_port
  import gio_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [4:0]  reg_addr,
  input  wire logic [8:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [8:0]  reg_rdata,
  // configuration straps
  input  wire logic [2:0]  cfg_pu_1m,
  input  wire logic        cfg_int0_alt,
  input  wire logic        cfg_int1_alt,
  input  wire logic        cfg_int2_en,
  input  wire logic        cfg_ir_large,
  input  wire logic        cfg_reset_pin,
  input  wire logic        cfg_crystal,
  input  wire logic        cfg_clkout,
  input  wire logic        cfg_extclk1_a2,
  input  wire logic        cfg_pwm3_a7,
  input  wire logic [1:0]  cfg_pwm2_pin,
  input  wire logic        cfg_pwm1_b4,
  // internal signals from timers and carrier
  input  wire logic        ir_carrier,
  input  wire logic        instr_clk,
  input  wire logic        pwm1,
  input  wire logic        pwm2,
  input  wire logic        pwm3,
  input  wire logic        buzzer2,
  input  wire logic        buzzer3,
  input  wire logic        timer1_toggle_output,
  // pads
  input  wire logic [17:0] pad_in,
  output logic      [17:0] pad_out,
  output logic      [17:0] pad_oe_n,
  output logic      [17:0] pad_pu_100k,
  output logic      [17:0] pad_pu_1m,
  output logic      [17:0] pad_pd,
  // events to the core
  output logic             irq,
  output logic             ext_int0,
  output logic             ext_int1,
  output logic             ext_int2,
  output logic             ext_reset_n,
  output logic             xtal_sel,
  output logic             ext_timer_clock0_t0,
  output logic             ext_timer_clock0_t1,
  output logic             ext_timer_clock1
);
  import gio_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]  latch_a, latch_b;
  logic [1:0]  latch_c;
  logic [7:0]  group_a_direction, group_b_direction;
  logic [1:0]  group_c_direction;
  logic [7:0]  group_a_pullup_ctrl, group_b_pullup_ctrl;
  logic [1:0]  group_c_pullup_ctrl, group_c_pulldown_ctrl;
  logic [7:0]  shared_pulldown_ctrl;
  logic [7:0]  group_b_opendrain_sel;
  logic [1:0]  group_c_opendrain_sel;
  logic [7:0]  group_a_change_select, group_b_change_select;
  logic [7:0]  power_control_reg, power_control_reg2;
  logic [7:0]  interrupt_flag_reg, interrupt_enable_reg;
  logic [7:0]  interrupt_edge_reg, ir_control_reg;
  logic [8:0]  alt_ctrl;
  logic [15:0] prev_ab;

  // ****************************************
  // decode
  // ****************************************
  wire        wr_hit_interrupt_flag_reg = reg_wr && (reg_addr == ADDR_INTERRUPT_FLAG_REG);
  wire [7:0]  wd8 = reg_wdata[7:0];
  wire [17:0] latch_all = {latch_c, latch_b, latch_a};
  wire [17:0] dir_all = {group_c_direction, group_b_direction,
                         group_a_direction};
  wire [17:0] pin_is_in = dir_all;

  // ext interrupt selects
  wire ext_int0_select = interrupt_edge_reg[BIT_EXT_INT0_SELECT];
  wire ext_int1_select = interrupt_edge_reg[BIT_EXT_INT1_SELECT];
  wire ext_int2_select = interrupt_edge_reg[BIT_EXT_INT2_SELECT] && cfg_int2_en;
  wire next_int0 = cfg_int0_alt ? pad_in[4] : pad_in[8];
  wire next_int1 = cfg_int1_alt ? pad_in[3] : pad_in[9];

  // pins claimed by an external interrupt lose level-change detect
  wire [15:0] ext_claim;
  assign ext_claim[3]  = ext_int1_select && cfg_int1_alt;
  assign ext_claim[4]  = ext_int0_select && cfg_int0_alt;
  assign ext_claim[5]  = ext_int2_select;
  assign ext_claim[8]  = ext_int0_select && !cfg_int0_alt;
  assign ext_claim[9]  = ext_int1_select && !cfg_int1_alt;
  assign ext_claim[2:0] = 3'h0;
  assign ext_claim[7:6] = 2'h0;
  assign ext_claim[15:10] = 6'h00;

  wire [15:0] chg_sel = {group_b_change_select, group_a_change_select}
                        & ~ext_claim;
  wire        level_change = |(chg_sel & (pad_in[15:0] ^ prev_ab));

  // raw pull enables before the input gate
  wire [17:0] pu_raw;
  wire [17:0] pd_raw;
  assign pu_raw[4:0] = group_a_pullup_ctrl[4:0];
  assign pu_raw[5]   = power_control_reg[BIT_PA5_PU];
  assign pu_raw[7:6] = group_a_pullup_ctrl[7:6];
  assign pu_raw[15:8]  = group_b_pullup_ctrl;
  assign pu_raw[17:16] = group_c_pullup_ctrl;
  assign pd_raw[3:0] = shared_pulldown_ctrl[3:0];
  assign pd_raw[4]   = 1'b0;
  assign pd_raw[5]   = group_a_pullup_ctrl[BIT_PA5_PD];
  assign pd_raw[7:6] = 2'h0;
  assign pd_raw[11:8]  = shared_pulldown_ctrl[7:4];
  assign pd_raw[15:12] = 4'h0;
  assign pd_raw[17:16] = group_c_pulldown_ctrl;

  // per-group strength strap, a5 has its own fixed resistor
  wire [17:0] strong_1m = {{2{cfg_pu_1m[2]}}, {8{cfg_pu_1m[1]}},
                           {2{cfg_pu_1m[0]}}, 1'b0, {5{cfg_pu_1m[0]}}};
  // open-drain selection
  wire [17:0] od_sel = {group_c_opendrain_sel, group_b_opendrain_sel,
                        2'h0, 1'b1, 5'h00};

  // alternate function overrides
  wire ir_carrier_enable    = ir_control_reg[BIT_IR_CARRIER_ENABLE];
  wire pwm1_oe = alt_ctrl[BIT_PWM1OE];
  wire pwm2_oe = alt_ctrl[BIT_PWM2OE];
  wire pwm3_oe = alt_ctrl[BIT_PWM3OE];
  wire bz2_en  = alt_ctrl[BIT_BUZZER2_ENABLE];
  wire bz3_en  = alt_ctrl[BIT_BUZZER3_ENABLE];
  wire t1_oe   = alt_ctrl[BIT_T1OE];
  wire clk_on_a7 = cfg_clkout && !cfg_crystal;

  logic [17:0] alt_en;
  logic [17:0] alt_val;
  always_comb
  begin
    alt_en  = 18'h00000;
    alt_val = 18'h00000;
    if (ir_carrier_enable && cfg_ir_large)
    begin
      alt_en[3]  = 1'b1;
      alt_val[3] = ir_carrier;
    end
    if (ir_carrier_enable && !cfg_ir_large)
    begin
      alt_en[9]  = 1'b1;
      alt_val[9] = ir_carrier;
    end
    if (pwm3_oe)
    begin
      alt_en[cfg_pwm3_a7 ? 7 : 2]  = 1'b1;
      alt_val[cfg_pwm3_a7 ? 7 : 2] = pwm3;
    end
    if (bz3_en)
    begin
      alt_en[2]  = 1'b1;
      alt_val[2] = buzzer3;
    end
    if (clk_on_a7)
    begin
      alt_en[7]  = 1'b1;
      alt_val[7] = instr_clk;
    end
    if (pwm2_oe)
    begin
      case (cfg_pwm2_pin)
        2'h1:
        begin
          alt_en[13]  = 1'b1;
          alt_val[13] = pwm2;
        end
        2'h2:
        begin
          alt_en[14]  = 1'b1;
          alt_val[14] = pwm2;
        end
        default:
        begin
          alt_en[10]  = 1'b1;
          alt_val[10] = pwm2;
        end
      endcase
    end
    if (bz2_en)
    begin
      alt_en[10]  = 1'b1;
      alt_val[10] = buzzer2;
    end
    if (pwm1_oe)
    begin
      alt_en[cfg_pwm1_b4 ? 12 : 11]  = 1'b1;
      alt_val[cfg_pwm1_b4 ? 12 : 11] = pwm1;
    end
    // toggle output last so it wins on b4
    if (t1_oe)
    begin
      alt_en[12]  = 1'b1;
      alt_val[12] = timer1_toggle_output;
    end
  end

  // crystal and reset pin take their pads away from gpio
  wire [17:0] taken = {10'h000, cfg_crystal, cfg_crystal,
                       cfg_reset_pin, 5'h00};
  wire [17:0] drive = (~dir_all | alt_en) & ~taken;
  wire [17:0] pu_on = pu_raw & pin_is_in & ~drive;
  wire [17:0] next_pu_1m   = pu_on & strong_1m;
  wire [17:0] next_pu_100k = pu_on & ~strong_1m;
  wire [17:0] next_pd      = pd_raw & pin_is_in & ~drive;
  wire [17:0] value = (alt_en & alt_val) | (~alt_en & latch_all);
  // open-drain: drive only a low level, release otherwise
  wire [17:0] next_oe_n = ~(drive & ~(od_sel & value));
  wire [17:0] rd_port = (pin_is_in & pad_in) | (~pin_is_in & latch_all);

  // read mux
  logic [8:0] next_rdata;
  always_comb
  begin
    if (reg_addr == ADDR_PORT_A)
      next_rdata = {1'b0, rd_port[7:0]};
    else if (reg_addr == ADDR_PORT_B)
      next_rdata = {1'b0, rd_port[15:8]};
    else if (reg_addr == ADDR_PORT_C)
      next_rdata = {7'h00, rd_port[17:16]};
    else if (reg_addr == ADDR_DIR_A)
      next_rdata = {1'b0, group_a_direction};
    else if (reg_addr == ADDR_DIR_B)
      next_rdata = {1'b0, group_b_direction};
    else if (reg_addr == ADDR_DIR_C)
      next_rdata = {7'h00, group_c_direction};
    else if (reg_addr == ADDR_PU_A)
      next_rdata = {1'b0, group_a_pullup_ctrl};
    else if (reg_addr == ADDR_PU_B)
      next_rdata = {1'b0, group_b_pullup_ctrl};
    else if (reg_addr == ADDR_PU_C)
      next_rdata = {7'h00, group_c_pullup_ctrl};
    else if (reg_addr == ADDR_PD_AB)
      next_rdata = {1'b0, shared_pulldown_ctrl};
    else if (reg_addr == ADDR_PD_C)
      next_rdata = {7'h00, group_c_pulldown_ctrl};
    else if (reg_addr == ADDR_OD_B)
      next_rdata = {1'b0, group_b_opendrain_sel};
    else if (reg_addr == ADDR_OD_C)
      next_rdata = {7'h00, group_c_opendrain_sel};
    else if (reg_addr == ADDR_CHG_A)
      next_rdata = {1'b0, group_a_change_select};
    else if (reg_addr == ADDR_CHG_B)
      next_rdata = {1'b0, group_b_change_select};
    else if (reg_addr == ADDR_POWER_CONTROL_REG)
      next_rdata = {1'b0, power_control_reg};
    else if (reg_addr == ADDR_PCON2)
      next_rdata = {1'b0, power_control_reg2};
    else if (reg_addr == ADDR_INTERRUPT_FLAG_REG)
      next_rdata = {1'b0, interrupt_flag_reg};
    else if (reg_addr == ADDR_INTERRUPT_ENABLE_REG)
      next_rdata = {1'b0, interrupt_enable_reg};
    else if (reg_addr == ADDR_INTERRUPT_EDGE_REG)
      next_rdata = {1'b0, interrupt_edge_reg};
    else if (reg_addr == ADDR_IR_CONTROL_REG)
      next_rdata = {1'b0, ir_control_reg};
    else if (reg_addr == ADDR_ALTCTL)
      next_rdata = alt_ctrl;
    else
      next_rdata = 9'h000;
  end

  // flag: set wins over a software write-zero in the same cycle
  logic [7:0] next_interrupt_flag_reg;
  always_comb
  begin
    next_interrupt_flag_reg = wr_hit_interrupt_flag_reg ? wd8 : interrupt_flag_reg;
    if (level_change)
      next_interrupt_flag_reg[BIT_LVL_FLAG] = 1'b1;
  end

  wire next_irq = interrupt_flag_reg[BIT_LVL_FLAG]
                  && interrupt_enable_reg[BIT_LVL_FLAG]
                  && power_control_reg2[BIT_GIE];

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      latch_a <= RST_ZERO;
      latch_b <= RST_ZERO;
      latch_c <= 2'h0;
      group_a_direction <= RST_DIR;
      group_b_direction <= RST_DIR;
      group_c_direction <= 2'h3;
      group_a_pullup_ctrl <= RST_ZERO;
      group_b_pullup_ctrl <= RST_ZERO;
      group_c_pullup_ctrl <= 2'h0;
      group_c_pulldown_ctrl <= 2'h0;
      shared_pulldown_ctrl <= RST_ZERO;
      group_b_opendrain_sel <= RST_ZERO;
      group_c_opendrain_sel <= 2'h0;
      group_a_change_select <= RST_ZERO;
      group_b_change_select <= RST_ZERO;
      power_control_reg <= RST_ZERO;
      power_control_reg2 <= RST_ZERO;
      interrupt_enable_reg <= RST_ZERO;
      interrupt_edge_reg <= RST_ZERO;
      ir_control_reg <= RST_ZERO;
      alt_ctrl <= RST_ALT;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_PORT_A) latch_a <= wd8;
      if (reg_addr == ADDR_PORT_B) latch_b <= wd8;
      if (reg_addr == ADDR_PORT_C) latch_c <= wd8[1:0];
      if (reg_addr == ADDR_DIR_A) group_a_direction <= wd8;
      if (reg_addr == ADDR_DIR_B) group_b_direction <= wd8;
      if (reg_addr == ADDR_DIR_C) group_c_direction <= wd8[1:0];
      if (reg_addr == ADDR_PU_A) group_a_pullup_ctrl <= wd8;
      if (reg_addr == ADDR_PU_B) group_b_pullup_ctrl <= wd8;
      if (reg_addr == ADDR_PU_C) group_c_pullup_ctrl <= wd8[1:0];
      if (reg_addr == ADDR_PD_AB) shared_pulldown_ctrl <= wd8;
      if (reg_addr == ADDR_PD_C) group_c_pulldown_ctrl <= wd8[1:0];
      if (reg_addr == ADDR_OD_B) group_b_opendrain_sel <= wd8;
      if (reg_addr == ADDR_OD_C) group_c_opendrain_sel <= wd8[1:0];
      if (reg_addr == ADDR_CHG_A) group_a_change_select <= wd8;
      if (reg_addr == ADDR_CHG_B) group_b_change_select <= wd8;
      if (reg_addr == ADDR_POWER_CONTROL_REG) power_control_reg <= wd8;
      if (reg_addr == ADDR_PCON2) power_control_reg2 <= wd8;
      if (reg_addr == ADDR_INTERRUPT_ENABLE_REG) interrupt_enable_reg <= wd8;
      if (reg_addr == ADDR_INTERRUPT_EDGE_REG) interrupt_edge_reg <= wd8;
      if (reg_addr == ADDR_IR_CONTROL_REG) ir_control_reg <= wd8;
      if (reg_addr == ADDR_ALTCTL) alt_ctrl <= reg_wdata;
    end
  end

  // ****************************************
  // status and pad outputs
  // ****************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      interrupt_flag_reg <= RST_ZERO;
      prev_ab <= 16'h0000;
      reg_rdata <= 9'h000;
      irq <= 1'b0;
      pad_out <= 18'h00000;
      pad_oe_n <= 18'h3FFFF;
      pad_pu_100k <= 18'h00000;
      pad_pu_1m <= 18'h00000;
      pad_pd <= 18'h00000;
      ext_int0 <= 1'b0;
      ext_int1 <= 1'b0;
      ext_int2 <= 1'b0;
      ext_reset_n <= 1'b1;
      xtal_sel <= 1'b0;
      ext_timer_clock0_t0 <= 1'b0;
      ext_timer_clock0_t1 <= 1'b0;
      ext_timer_clock1 <= 1'b0;
    end
    else
    begin
      interrupt_flag_reg <= next_interrupt_flag_reg;
      prev_ab <= pad_in[15:0];
      reg_rdata <= reg_rd ? next_rdata : 9'h000;
      irq <= next_irq;
      pad_out <= value;
      pad_oe_n <= next_oe_n;
      pad_pu_100k <= next_pu_100k;
      pad_pu_1m <= next_pu_1m;
      pad_pd <= next_pd;
      ext_int0 <= ext_int0_select && next_int0;
      ext_int1 <= ext_int1_select && next_int1;
      ext_int2 <= ext_int2_select && pad_in[5];
      ext_reset_n <= !(cfg_reset_pin && !pad_in[5]);
      xtal_sel <= cfg_crystal;
      ext_timer_clock0_t0 <= alt_ctrl[BIT_TIMER0_SOURCE_SEL] && !alt_ctrl[BIT_T0LCK]
                             && pad_in[4];
      ext_timer_clock0_t1 <= alt_ctrl[BIT_TIMER1_SOURCE_SEL] && pad_in[4];
      ext_timer_clock1 <= cfg_extclk1_a2 ? pad_in[2] : pad_in[1];
    end
  end

endmodule

`default_nettype wire

// ==== tb/gio_pad_model.sv ====
// board side of the pads: pulls, external drivers, floating pins
// assumes the pad wire is resolved once per pin from all parties
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// pad model
// ****************************************
module gio_pad_model (
  // clock
  input  wire logic        core_clk,
  // pad controls from the port
  input  wire logic [17:0] pad_out,
  input  wire logic [17:0] pad_oe_n,
  input  wire logic [17:0] pad_pu_100k,
  input  wire logic [17:0] pad_pu_1m,
  input  wire logic [17:0] pad_pd,
  // board drivers
  input  wire logic [17:0] ext_en,
  input  wire logic [17:0] ext_val,
  output logic      [17:0] pad_in
);
  logic [17:0] float_pat = 18'h15555;
  wire  logic [17:0] pull_up = pad_pu_100k | pad_pu_1m;
  // a floating pin wanders, so a stale value never reads as good
  always @(posedge core_clk)
    float_pat <= ~float_pat;
  // port driver first, then board, then resistors
  always_comb
    for (int i = 0; i < 18; i++)
      pad_in[i] = !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                  pull_up[i] ? 1'h1 : pad_pd[i] ? 1'h0 : float_pat[i];
endmodule
`default_nettype wire

// ==== tb/gio_port_checker.sv ====
// checker: pad and event relations of the gpio port
// assumes a bind into gio_port, one clock domain
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// checker
// ****************************************
module gio_port_checker (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // register port and straps
  input wire logic        reg_rd,
  input wire logic [8:0]  reg_rdata,
  input wire logic        cfg_reset_pin,
  input wire logic        cfg_crystal,
  input wire logic        cfg_extclk1_a2,
  // pads and events
  input wire logic [17:0] pad_in,
  input wire logic [17:0] pad_out,
  input wire logic [17:0] pad_oe_n,
  input wire logic [17:0] pad_pu_100k,
  input wire logic [17:0] pad_pu_1m,
  input wire logic [17:0] pad_pd,
  input wire logic        ext_reset_n,
  input wire logic        xtal_sel,
  input wire logic        ext_timer_clock1
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 9'h000)
    else $error("read data outside read cycle");
  a5_open_drain_a: assert property (
    !pad_oe_n[5] |-> !pad_out[5])
    else $error("pin a5 driven high");
  pull_input_a: assert property (
    ((pad_pu_100k | pad_pu_1m | pad_pd) & ~pad_oe_n) == 18'h00000)
    else $error("pull on a driven pin");
  no_pulldown_a: assert property (
    {pad_pd[15:12], pad_pd[7:6], pad_pd[4]} == 7'h00)
    else $error("pull-down on pin without one");
  pu_exclusive_a: assert property (
    (pad_pu_100k & pad_pu_1m) == 18'h00000 && !pad_pu_1m[5])
    else $error("both pull-up strengths on");
  crystal_pins_a: assert property (
    !$past(rst) && $past(cfg_crystal) && cfg_crystal |->
      xtal_sel && pad_oe_n[7:6] == 2'h3)
    else $error("crystal pins not released");
  reset_pin_a: assert property (
    !$past(rst) |->
      ext_reset_n == !($past(cfg_reset_pin) && !$past(pad_in[5])))
    else $error("external reset not following pin a5");
  timer_clock1_a: assert property (
    !$past(rst) |-> ext_timer_clock1 ==
      ($past(cfg_extclk1_a2) ? $past(pad_in[2]) : $past(pad_in[1])))
    else $error("timer 2/3 clock on wrong pin");
endmodule
bind gio_port gio_port_checker u_gio_port_checker (.*);
`default_nettype wire

// ==== tb/gio_port_tb.sv ====
// testbench: register table, pad control and alternate routing
// assumes the pad model on the pads and the checker bound in
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// gpio port testbench
// ****************************************
module gio_port_tb;
  import gio_pkg::*;
  typedef struct {logic [4:0] a; logic [8:0] w, r0, e;} gio_row_t;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [4:0] reg_addr = 0;
  logic [8:0] reg_wdata = 0, d;
  logic [8:0] reg_rdata;
  logic [2:0] cfg_pu_1m = 0;
  logic [1:0] cfg_pwm2_pin = 0;
  logic cfg_int0_alt = 0, cfg_int1_alt = 0, cfg_int2_en = 0;
  logic cfg_ir_large = 0, cfg_reset_pin = 0, cfg_crystal = 0;
  logic cfg_clkout = 0, cfg_extclk1_a2 = 0, cfg_pwm3_a7 = 0;
  logic cfg_pwm1_b4 = 0, ir_carrier = 0, instr_clk = 0;
  logic pwm1 = 0, pwm2 = 0, pwm3 = 0, buzzer2 = 0, buzzer3 = 0;
  logic timer1_toggle_output = 0;
  logic [17:0] pad_in, pad_out, pad_oe_n, pad_pu_100k, pad_pu_1m, pad_pd;
  logic [17:0] ext_en = 0, ext_val = 0;
  logic irq, ext_int0, ext_int1, ext_int2, ext_reset_n, xtal_sel;
  logic ext_timer_clock0_t0, ext_timer_clock0_t1, ext_timer_clock1;
  int   errors = 0, compares = 0;
  int   pin_of [3] = '{8, 9, 5};
  gio_row_t rows [11] = '{
    '{ADDR_DIR_A, 9'h05A, 9'h0FF, 9'h05A}, '{ADDR_DIR_C, 9'h0FF, 9'h003, 9'h003},
    '{ADDR_PU_B, 9'h0C3, 9'h000, 9'h0C3}, '{ADDR_PU_C, 9'h0FF, 9'h000, 9'h003},
    '{ADDR_PD_AB, 9'h096, 9'h000, 9'h096}, '{ADDR_PD_C, 9'h0FF, 9'h000, 9'h003},
    '{ADDR_OD_B, 9'h069, 9'h000, 9'h069}, '{ADDR_OD_C, 9'h0FF, 9'h000, 9'h003},
    '{ADDR_CHG_A, 9'h081, 9'h000, 9'h081}, '{ADDR_ALTCTL, 9'h103, 9'h000, 9'h103},
    '{5'h1F, 9'h0FF, 9'h000, 9'h000}};
  gio_port      u_gio_port (.*);
  gio_pad_model u_gio_pad_model (.*);
  initial forever #12.5 core_clk = ~core_clk;
  task automatic wr(logic [4:0] a, logic [8:0] w);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= w;
    reg_wr    <= 1'h1;
    @(posedge core_clk);
    reg_wr    <= 1'h0;
  endtask
  task automatic rd(logic [4:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge core_clk);
    reg_rd   <= 1'h0;
    #1 d = reg_rdata;
  endtask
  // outputs trail registers by one cycle, three leaves margin
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(string n, logic [17:0] s, logic [17:0] e);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge core_clk);
    errors++;
    end_of_test();
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'h0;
    foreach (rows[i])
    begin
      rd(rows[i].a);
      chk("reset value", d, rows[i].r0);
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk("readback", d, rows[i].e);
    end
    $display("test registers done");
    @(posedge core_clk);
    rst <= 1'h1;
    settle();
    chk("reset oe", pad_oe_n, 18'h3FFFF);
    chk("reset pulls", pad_pu_100k | pad_pu_1m | pad_pd, 18'h0);
    @(posedge core_clk);
    rst    <= 1'h0;
    ext_en <= 18'h3FFFF;
    wr(ADDR_DIR_A, 9'h000);
    wr(ADDR_PORT_A, 9'h0A5);
    settle();
    chk("oe a", pad_oe_n[7:0], 8'h20);
    rd(ADDR_PORT_A);
    chk("latch a", d, 9'h0A5);
    wr(ADDR_DIR_A, 9'h0FF);
    ext_val[7:0] <= 8'h3C;
    settle();
    rd(ADDR_PORT_A);
    chk("pad a", d, 9'h03C);
    $display("test direction done");
    wr(ADDR_CHG_A, 9'h001);
    wr(ADDR_INTERRUPT_ENABLE_REG, 9'h002);
    wr(ADDR_PCON2, 9'h080);
    wr(ADDR_INTERRUPT_FLAG_REG, 9'h000);
    ext_val[0] <= 1'h1;
    settle();
    rd(ADDR_INTERRUPT_FLAG_REG);
    chk("change flag", d[1], 1'h1);
    chk("irq", irq, 1'h1);
    wr(ADDR_PCON2, 9'h000);
    settle();
    chk("irq masked", irq, 1'h0);
    wr(ADDR_CHG_A, 9'h020);
    wr(ADDR_CHG_B, 9'h003);
    wr(ADDR_INTERRUPT_FLAG_REG, 9'h000);
    cfg_int2_en <= 1'h1;
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_INTERRUPT_EDGE_REG, 9'h010 << i);
      ext_val[pin_of[i]] <= 1'h1;
      settle();
      chk("ext int", {ext_int2, ext_int1, ext_int0}, 3'h1 << i);
      @(posedge core_clk);
      ext_val[pin_of[i]] <= 1'h0;
      settle();
      chk("ext int low", {ext_int2, ext_int1, ext_int0}, 3'h0);
    end
    rd(ADDR_INTERRUPT_FLAG_REG);
    chk("change masked", d[1], 1'h0);
    wr(ADDR_INTERRUPT_EDGE_REG, 9'h030);
    cfg_int0_alt <= 1'h1;
    cfg_int1_alt <= 1'h1;
    ext_val[4:3] <= 2'h3;
    settle();
    chk("ext int alt", {ext_int1, ext_int0}, 2'h3);
    $display("test interrupts done");
    wr(ADDR_PU_B, 9'h002);
    wr(ADDR_IR_CONTROL_REG, 9'h001);
    ir_carrier <= 1'h1;
    settle();
    chk("ir b1", {pad_out[9], pad_oe_n[9]}, 2'h2);
    chk("ir pull off", pad_pu_100k[9], 1'h0);
    @(posedge core_clk);
    cfg_ir_large <= 1'h1;
    settle();
    chk("ir a3", {pad_out[3], pad_oe_n[3]}, 2'h2);
    wr(ADDR_IR_CONTROL_REG, 9'h000);
    settle();
    chk("ir off", pad_oe_n[3], 1'h1);
    wr(ADDR_ALTCTL, 9'h005);
    cfg_extclk1_a2 <= 1'h1;
    ext_val[2] <= 1'h1;
    settle();
    chk("timer clocks", {ext_timer_clock0_t0, ext_timer_clock0_t1,
        ext_timer_clock1}, 3'h7);
    wr(ADDR_ALTCTL, 9'h108);
    cfg_pwm1_b4 <= 1'h1;
    timer1_toggle_output <= 1'h1;
    settle();
    chk("toggle over pwm1", pad_out[12], 1'h1);
    wr(ADDR_ALTCTL, 9'h0F8);
    {timer1_toggle_output, cfg_pwm1_b4, cfg_pwm2_pin} <= 4'h1;
    {pwm1, pwm2, pwm3, buzzer2, buzzer3, cfg_pwm3_a7} <= 6'h3F;
    settle();
    chk("alt outs", {pad_out[7], pad_out[13], pad_out[11:10],
        pad_out[2]}, 5'h1F);
    @(posedge core_clk);
    {pwm1, pwm2, pwm3, buzzer2, buzzer3} <= 5'h00;
    settle();
    chk("alt outs low", {pad_out[7], pad_out[13], pad_out[11:10],
        pad_out[2]}, 5'h00);
    wr(ADDR_ALTCTL, 9'h000);
    {cfg_clkout, instr_clk} <= 2'h3;
    settle();
    chk("clock out", {pad_out[7], pad_oe_n[7]}, 2'h2);
    @(posedge core_clk);
    cfg_crystal <= 1'h1;
    settle();
    chk("crystal", {xtal_sel, pad_oe_n[7:6]}, 3'h7);
    @(posedge core_clk);
    {cfg_crystal, cfg_clkout, cfg_reset_pin} <= 3'h1;
    ext_val[5] <= 1'h0;
    settle();
    chk("reset pin", ext_reset_n, 1'h0);
    $display("test alternates done");
    wr(ADDR_PU_A, 9'h0FF);
    wr(ADDR_PD_AB, 9'h0AF);
    wr(ADDR_POWER_CONTROL_REG, 9'h010);
    wr(ADDR_PU_B, 9'h0F0);
    wr(ADDR_PU_C, 9'h001);
    wr(ADDR_PD_C, 9'h002);
    cfg_reset_pin <= 1'h0;
    settle();
    chk("pull-up", pad_pu_100k & 18'h3FFDF, 18'h1F0DF);
    chk("a5 pull-up", pad_pu_100k[5] | pad_pu_1m[5], 1'h1);
    chk("pull-down", pad_pd, 18'h20A2F);
    @(posedge core_clk);
    cfg_pu_1m <= 3'h7;
    settle();
    chk("pull 1m", pad_pu_1m & 18'h3FFDF, 18'h1F0DF);
    wr(ADDR_DIR_B, 9'h000);
    wr(ADDR_PORT_B, 9'h0FF);
    wr(ADDR_OD_B, 9'h00F);
    settle();
    chk("pull on output", {pad_pu_1m[15:8], pad_pd[15:8]}, 16'h0);
    chk("open drain b", pad_oe_n[15:8], 8'h0F);
    $display("test pulls done");
    end_of_test();
  end
endmodule
`default_nettype wire
